/* File: hdl/tcc_capture_compare.sv */
// capture/compare unit beside a 16-bit timer, with an Avalon-MM register slave
//
// How it works
// R1: value byte pair and control are read/write
// R2: mode 0000 turns unit off, clears state
// R3: modes 0100-0111 pick capture edge and prescale
// R4: modes 1000/1001 drive output high/low, flag
// R5: mode 1010 only flags, pin untouched
// R6: modes 11xx are PWM; bits 5:4 duty
// R7: control bits 7:6 read as zero
// R8: capture copies full timer into value pair
// R9: capture sets sticky flag until software clears
// R10: newer capture overwrites unread older value
// R11: capture samples pin level even when driven
// R12: software makes pin input for capture
// R13: software runs timer synchronously for capture/compare
// R14: software masks irq while changing capture mode
// R15: prescaler cleared when off or not capturing
// R16: prescale switch keeps counter; write zero first
// R17: compare value against timer every cycle
// R18: software makes pin output for compare
// R19: writing zero to control forces output low
// R20: mode 1011 triggers, resets timer next tick
// R21: trigger starts conversion when converter enabled
// R22: match removed before tick skips timer reset
// R23: pin synchronised, edges from previous level
// R24: compare flag once per entry into equality
`timescale 1ns/1ps

module tcc_capture_compare (
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   input wire tcc_pkg::tcc_avl_req_type avl_req,
   output logic [31:0] avl_readdata,
   output logic avl_waitrequest,
   input wire tcc_pkg::tcc_timer_type timer_in,
   input wire logic shared_event_pin_in,
   output logic shared_event_pin_out,
   input wire logic adc_enable,
   output logic special_trigger,
   output logic adc_start,
   output logic timer_clear,
   output logic unit_irq_flag,
   output logic unit_irq_request,
   output logic [1:0] pwm_duty_lsbs,
   output logic pwm_mode
);

   // ====================================================================
   // state
   logic [7:0] ctrl_reg;
   logic [15:0] match_value_pair_reg;
   logic flag_reg;
   logic irq_enable_reg;
   logic ack_reg;
   logic [31:0] readdata_reg;
   logic sync1_reg;
   logic sync2_reg;
   logic pin_prev_reg;
   logic [3:0] presc_reg;
   logic [3:0] presc_next;
   logic eq_prev_reg;
   logic pending_reg;
   logic cmp_out_reg;

   logic [3:0] mode;
   logic mode_off;
   logic capture_mode;
   logic compare_mode;
   logic req;
   logic wr_go;
   logic [7:0] wr_byte;
   logic [7:0] reg_index;
   logic addr_aligned;
   logic ctrl_wr;
   logic flag_wr;
   logic en_wr;
   logic low_wr;
   logic high_wr;
   logic pin_rise;
   logic pin_fall;
   logic cap_event;
   logic eq;
   logic match_rise;

   assign mode = ctrl_reg[tcc_pkg::MODE_MSB:tcc_pkg::MODE_LSB];
   assign mode_off = (mode == tcc_pkg::MODE_OFF);
   assign capture_mode = (mode[3:2] == 2'b01);
   assign compare_mode = (mode[3:2] == 2'b10);
   assign pwm_mode = (mode[3:2] == 2'b11); // [R6]
   assign pwm_duty_lsbs = {ctrl_reg[tcc_pkg::DUTY_LSB_HI_BIT], ctrl_reg[tcc_pkg::DUTY_LSB_LO_BIT]};

   // ====================================================================
   // bus slave: one wait cycle, answer on the second edge of a request
   assign req = avl_req.read | avl_req.write;
   assign avl_waitrequest = req & ~(ack_reg & ce);
   assign avl_readdata = readdata_reg;
   assign reg_index = avl_req.address[9:2];
   assign addr_aligned = (avl_req.address[1:0] == 2'b00);
   assign wr_go = ce & ack_reg & avl_req.write & avl_req.byteenable[0];
   assign wr_byte = avl_req.writedata[7:0];
   assign ctrl_wr = wr_go & addr_aligned & (reg_index == tcc_pkg::IDX_UNIT_MODE_CONTROL);
   assign flag_wr = wr_go & addr_aligned & (reg_index == tcc_pkg::IDX_PERIPHERAL_FLAG);
   assign en_wr = wr_go & addr_aligned & (reg_index == tcc_pkg::IDX_PERIPHERAL_ENABLE);
   assign low_wr = wr_go & addr_aligned & (reg_index == tcc_pkg::IDX_MATCH_VALUE_LOW);
   assign high_wr = wr_go & addr_aligned & (reg_index == tcc_pkg::IDX_MATCH_VALUE_HIGH);

   always_ff @(posedge clk) begin
      if (srst) begin
         ack_reg <= 1'b0;
      end else if (ce) begin
         ack_reg <= req & ~ack_reg;
      end
   end

   // read data is prepared in the wait cycle so it stands at the answering edge
   always_ff @(posedge clk) begin
      if (srst) begin
         readdata_reg <= 32'h0000_0000;
      end else if (ce && req && !ack_reg) begin
         readdata_reg <= 32'h0000_0000;
         if (!addr_aligned) begin
            readdata_reg <= 32'h0000_0000;
         end else if (reg_index == tcc_pkg::IDX_PERIPHERAL_FLAG) begin
            readdata_reg[tcc_pkg::UNIT_IRQ_BIT] <= flag_reg;
         end else if (reg_index == tcc_pkg::IDX_PERIPHERAL_ENABLE) begin
            readdata_reg[tcc_pkg::UNIT_IRQ_BIT] <= irq_enable_reg;
         end else if (reg_index == tcc_pkg::IDX_MATCH_VALUE_LOW) begin
            readdata_reg[7:0] <= match_value_pair_reg[7:0]; // [R1]
         end else if (reg_index == tcc_pkg::IDX_MATCH_VALUE_HIGH) begin
            readdata_reg[7:0] <= match_value_pair_reg[15:8]; // [R1]
         end else if (reg_index == tcc_pkg::IDX_UNIT_MODE_CONTROL) begin
            readdata_reg[7:0] <= {2'b00, ctrl_reg[5:0]}; // [R7]
         end
      end
   end

   // ====================================================================
   // control and enable registers
   always_ff @(posedge clk) begin
      if (srst) begin
         ctrl_reg <= tcc_pkg::UNIT_MODE_CONTROL_RESET;
      end else if (ctrl_wr) begin
         // unimplemented top bits are never stored
         ctrl_reg <= {2'b00, wr_byte[tcc_pkg::CTRL_IMPL_MSB:0]}; // [R1] [R7]
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         irq_enable_reg <= tcc_pkg::PERIPHERAL_ENABLE_RESET[tcc_pkg::UNIT_IRQ_BIT];
      end else if (en_wr) begin
         irq_enable_reg <= wr_byte[tcc_pkg::UNIT_IRQ_BIT];
      end
   end

   assign unit_irq_flag = flag_reg;
   assign unit_irq_request = flag_reg & irq_enable_reg; // [R5]

   // ====================================================================
   // capture pin: two-stage synchroniser, then edge detect on the second stage
   always_ff @(posedge clk) begin
      if (srst) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         pin_prev_reg <= 1'b0;
      end else if (ce) begin
         // the pad level is sampled whoever drives it, so a port write can capture
         sync1_reg <= shared_event_pin_in; // [R11]
         sync2_reg <= sync1_reg; // [R23]
         pin_prev_reg <= sync2_reg; // [R23]
      end
   end

   assign pin_rise = sync2_reg & ~pin_prev_reg; // [R23]
   assign pin_fall = ~sync2_reg & pin_prev_reg; // [R23]

   // prescaler and event select; switching between capture modes keeps the count
   always_comb begin
      presc_next = presc_reg;
      cap_event = 1'b0;
      case (mode)
         tcc_pkg::MODE_CAP_FALL: begin
            cap_event = pin_fall; // [R3]
         end
         tcc_pkg::MODE_CAP_RISE: begin
            cap_event = pin_rise; // [R3]
         end
         tcc_pkg::MODE_CAP_RISE4: begin
            if (pin_rise) begin
               cap_event = (presc_reg >= tcc_pkg::PRESC_LAST_4); // [R3]
               presc_next = cap_event ? 4'h0 : presc_reg + 4'h1; // [R16]
            end
         end
         tcc_pkg::MODE_CAP_RISE16: begin
            if (pin_rise) begin
               cap_event = (presc_reg == tcc_pkg::PRESC_LAST_16); // [R3]
               presc_next = cap_event ? 4'h0 : presc_reg + 4'h1; // [R16]
            end
         end
         default: begin
            presc_next = 4'h0; // [R15]
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         presc_reg <= 4'h0; // [R15]
      end else if (ce) begin
         presc_reg <= presc_next; // [R2] [R15]
      end
   end

   // ====================================================================
   // value pair: software writes bytes, a capture overwrites both at once
   always_ff @(posedge clk) begin
      if (srst) begin
         match_value_pair_reg <= tcc_pkg::MATCH_VALUE_RESET;
      end else if (ce) begin
         if (cap_event) begin
            // an unread older capture is lost; capture beats a same-cycle write
            match_value_pair_reg <= timer_in.count; // [R8] [R10]
         end else begin
            if (low_wr) begin
               match_value_pair_reg[7:0] <= wr_byte; // [R1]
            end
            if (high_wr) begin
               match_value_pair_reg[15:8] <= wr_byte; // [R1]
            end
         end
      end
   end

   // ====================================================================
   // compare: equality checked each cycle, acted on only on entry into it
   assign eq = (timer_in.count == match_value_pair_reg); // [R17]
   assign match_rise = compare_mode & eq & ~eq_prev_reg; // [R24]

   always_ff @(posedge clk) begin
      if (srst) begin
         eq_prev_reg <= 1'b0;
      end else if (ce) begin
         eq_prev_reg <= compare_mode & eq; // [R2] [R24]
      end
   end

   // compare output latch, separate from the port data latch
   always_ff @(posedge clk) begin
      if (srst) begin
         cmp_out_reg <= 1'b0;
      end else if (ce) begin
         if (ctrl_wr && wr_byte[5:0] == 6'h00) begin
            cmp_out_reg <= 1'b0; // [R19]
         end else if (match_rise && mode == tcc_pkg::MODE_CMP_SET) begin
            cmp_out_reg <= 1'b1; // [R4]
         end else if (match_rise && mode == tcc_pkg::MODE_CMP_CLEAR) begin
            cmp_out_reg <= 1'b0; // [R4]
         end
      end
   end

   assign shared_event_pin_out = cmp_out_reg;

   // sticky flag: hardware set wins over a same-cycle software clear
   always_ff @(posedge clk) begin
      if (srst) begin
         flag_reg <= tcc_pkg::PERIPHERAL_FLAG_RESET[tcc_pkg::UNIT_IRQ_BIT];
      end else if (ce) begin
         if (cap_event || match_rise) begin
            flag_reg <= 1'b1; // [R9] [R4] [R5] [R17]
         end else if (flag_wr) begin
            flag_reg <= wr_byte[tcc_pkg::UNIT_IRQ_BIT];
         end
      end
   end

   // ====================================================================
   // special event: trigger now, timer clear held until the next timer tick
   assign special_trigger = match_rise & (mode == tcc_pkg::MODE_CMP_TRIGGER); // [R20]
   assign adc_start = special_trigger & adc_enable; // [R21]
   // a rewritten value pair that breaks equality drops the clear
   // a match in a tick cycle clears at that same tick, or a free-running timer never wraps
   assign timer_clear = (special_trigger | pending_reg) & eq
                        & (mode == tcc_pkg::MODE_CMP_TRIGGER); // [R20] [R22]

   always_ff @(posedge clk) begin
      if (srst) begin
         pending_reg <= 1'b0;
      end else if (ce) begin
         if (mode != tcc_pkg::MODE_CMP_TRIGGER || timer_in.tick) begin
            pending_reg <= 1'b0; // [R2] [R22]
         end else if (special_trigger) begin
            pending_reg <= 1'b1; // [R20]
         end
      end
   end

   // ====================================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   sequence s_cap_fires;
      ce && cap_event;
   endsequence

   a_ctrl_top_zero: assert property (ctrl_reg[7:6] == 2'b00) // [R7]
      else $error("control bits 7:6 not zero");
   a_off_clears_presc: assert property (ce && !capture_mode |=> presc_reg == 4'h0) // [R15]
      else $error("prescaler not cleared outside capture");
   a_off_no_action: assert property (mode_off // [R2]
      |-> !match_rise && !cap_event && !timer_clear)
      else $error("unit acted while off");
   a_capture_loads: assert property (s_cap_fires // [R8]
      |=> match_value_pair_reg == $past(timer_in.count))
      else $error("capture did not load timer value");
   a_capture_flag: assert property (s_cap_fires |=> flag_reg) // [R9]
      else $error("capture did not set flag");
   a_rise4_count: assert property (ce && mode == tcc_pkg::MODE_CAP_RISE4 && pin_rise // [R3]
      && presc_reg == tcc_pkg::PRESC_LAST_4 |-> cap_event)
      else $error("fourth rising edge missed");
   a_set_output: assert property (ce && match_rise && mode == tcc_pkg::MODE_CMP_SET // [R4]
      && !ctrl_wr |=> shared_event_pin_out)
      else $error("output not driven high on match");
   a_clear_output: assert property (ce && match_rise && mode == tcc_pkg::MODE_CMP_CLEAR // [R4]
      |=> !shared_event_pin_out)
      else $error("output not driven low on match");
   a_soft_keeps_pin: assert property (ce && mode == tcc_pkg::MODE_CMP_SOFT && !ctrl_wr // [R5]
      |=> $stable(shared_event_pin_out))
      else $error("pin changed in flag-only mode");
   a_ctrl_zero_low: assert property (ctrl_wr && wr_byte[5:0] == 6'h00 // [R19]
      |=> !shared_event_pin_out ##1 mode_off || ctrl_wr)
      else $error("output latch not forced low");
   a_match_once: assert property (compare_mode && eq_prev_reg |-> !match_rise) // [R24]
      else $error("repeated match event");
   a_trigger_adc: assert property (special_trigger |-> adc_start == adc_enable) // [R21]
      else $error("conversion start does not follow trigger");
   a_skip_reset: assert property (pending_reg && !eq |-> !timer_clear) // [R22]
      else $error("timer clear without match");
   a_trigger_clear: assert property (ce && special_trigger && !timer_in.tick && !ctrl_wr // [R20]
      |=> timer_clear || !eq)
      else $error("timer clear not requested after trigger");
   a_tick_clears: assert property (special_trigger && timer_in.tick |-> timer_clear) // [R20]
      else $error("timer clear missed on the tick of a match");
   a_flag_sticky: assert property (ce && flag_reg && !flag_wr |=> flag_reg) // [R9]
      else $error("flag dropped without software clear");

endmodule

/* File: hdl/tcc_pkg.sv */
// package for the timer capture/compare unit: register map, fields, modes, bus carrier
package tcc_pkg;

   // ====================================================================
   // register indices; byte address on the bus is four times the index
   localparam logic [7:0] IDX_PERIPHERAL_FLAG = 8'h0c;
   localparam logic [7:0] IDX_MATCH_VALUE_LOW = 8'h15;
   localparam logic [7:0] IDX_MATCH_VALUE_HIGH = 8'h16;
   localparam logic [7:0] IDX_UNIT_MODE_CONTROL = 8'h17;
   localparam logic [7:0] IDX_PERIPHERAL_ENABLE = 8'h8c;

   localparam int ADDR_WIDTH = 10;
   localparam int DATA_WIDTH = 32;

   // ====================================================================
   // field positions and reset values
   localparam int UNIT_IRQ_BIT = 2;
   localparam int MODE_LSB = 0;
   localparam int MODE_MSB = 3;
   localparam int DUTY_LSB_LO_BIT = 4;
   localparam int DUTY_LSB_HI_BIT = 5;
   localparam int CTRL_IMPL_MSB = 5;
   localparam logic [7:0] PERIPHERAL_FLAG_RESET = 8'h00;
   localparam logic [7:0] UNIT_MODE_CONTROL_RESET = 8'h00;
   localparam logic [7:0] PERIPHERAL_ENABLE_RESET = 8'h00;
   localparam logic [15:0] MATCH_VALUE_RESET = 16'h0000;

   // ====================================================================
   // mode select encodings
   localparam logic [3:0] MODE_OFF = 4'h0;
   localparam logic [3:0] MODE_CAP_FALL = 4'h4;
   localparam logic [3:0] MODE_CAP_RISE = 4'h5;
   localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
   localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
   localparam logic [3:0] MODE_CMP_SET = 4'h8;
   localparam logic [3:0] MODE_CMP_CLEAR = 4'h9;
   localparam logic [3:0] MODE_CMP_SOFT = 4'ha;
   localparam logic [3:0] MODE_CMP_TRIGGER = 4'hb;

   // prescaler terminal counts: every 4th and every 16th rising edge
   localparam logic [3:0] PRESC_LAST_4 = 4'h3;
   localparam logic [3:0] PRESC_LAST_16 = 4'hf;

   // ====================================================================
   // bus request carrier
   typedef struct packed {
      logic read;
      logic write;
      logic [ADDR_WIDTH-1:0] address;
      logic [DATA_WIDTH-1:0] writedata;
      logic [3:0] byteenable;
   } tcc_avl_req_type;

   // timer view: current count and one-cycle tick of the timer clock
   typedef struct packed {
      logic [15:0] count;
      logic tick;
   } tcc_timer_type;

endpackage

/* File: verif/tb_top.sv */
// self-checking bench for the capture/compare unit
`timescale 1ns/1ps

module tb_top;
   localparam logic [7:0] FLG = tcc_pkg::IDX_PERIPHERAL_FLAG;
   localparam logic [7:0] LO = tcc_pkg::IDX_MATCH_VALUE_LOW;
   localparam logic [7:0] HI = tcc_pkg::IDX_MATCH_VALUE_HIGH;
   localparam logic [7:0] CTL = tcc_pkg::IDX_UNIT_MODE_CONTROL;
   localparam logic [7:0] ENA = tcc_pkg::IDX_PERIPHERAL_ENABLE;
   logic clk = 1'b0;
   logic srst = 1'b1;
   tcc_pkg::tcc_avl_req_type avl_req = '0;
   tcc_pkg::tcc_timer_type timer;
   logic [31:0] avl_readdata;
   logic [31:0] rd_data;
   logic avl_waitrequest, pin_out, trig, adc_start, timer_clear, irq_flag, irq_req, pwm_mode;
   logic pin = 1'b0;
   logic adc_enable = 1'b0;
   logic run = 1'b0;
   logic load = 1'b0;
   logic saw_trig = 1'b0;
   logic saw_adc = 1'b0;
   logic [15:0] load_value = 16'h0000;
   logic [1:0] duty;
   logic [3:0] cmp_modes [4] = '{tcc_pkg::MODE_CMP_SET, tcc_pkg::MODE_CMP_CLEAR,
                                 tcc_pkg::MODE_CMP_SET, tcc_pkg::MODE_CMP_SOFT};
   logic cmp_pin [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
   logic ce = 1'b1;
   int failures = 0;
   int checked = 0;

   always #4 clk = ~clk;

   tcc_capture_compare i_tcc_capture_compare (
      .clk(clk), .srst(srst), .ce(ce), .avl_req(avl_req), .avl_readdata(avl_readdata),
      .avl_waitrequest(avl_waitrequest), .timer_in(timer), .shared_event_pin_in(pin),
      .shared_event_pin_out(pin_out), .adc_enable(adc_enable), .special_trigger(trig),
      .adc_start(adc_start), .timer_clear(timer_clear), .unit_irq_flag(irq_flag),
      .unit_irq_request(irq_req), .pwm_duty_lsbs(duty), .pwm_mode(pwm_mode)
   );

   tcc_timer_model i_tcc_timer_model (
      .clk(clk), .srst(srst), .run(run), .load(load), .load_value(load_value),
      .timer_clear(timer_clear), .timer(timer)
   );

   // trigger pulses last one cycle, so they are caught on every edge
   always @(posedge clk) begin
      if (trig === 1'b1) saw_trig <= 1'b1;
      if (adc_start === 1'b1) saw_adc <= 1'b1;
   end

   // ====================================================================
   // shared tasks
   task automatic close_out;
      if (failures == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // request held until waitrequest is sampled low; only the watchdog ends a hang
   task automatic access(input logic rd, input logic [7:0] idx, input logic [7:0] data);
      avl_req <= {rd, ~rd, idx, 2'b00, 24'h000000, data, 4'hf};
      do begin
         @(posedge clk);
      end while (avl_waitrequest !== 1'b0);
      rd_data = avl_readdata;
      avl_req <= '0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] data);
      access(1'b0, idx, data);
   endtask

   task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
      access(1'b1, idx, 8'h00);
      chk(rd_data, {24'h000000, exp});
   endtask

   // pin held long enough to pass the synchroniser and edge detector
   task automatic pin_to(input logic v);
      pin <= v;
      repeat (5) @(posedge clk);
   endtask

   task automatic rises(input int k);
      repeat (k) begin
         pin_to(1'b1);
         pin_to(1'b0);
      end
   endtask

   task automatic set_timer(input logic [15:0] v);
      load_value <= v;
      load <= 1'b1;
      @(posedge clk);
      load <= 1'b0;
   endtask

   task automatic tick_once;
      run <= 1'b1;
      @(posedge clk);
      run <= 1'b0;
      @(posedge clk);
   endtask

   // ====================================================================
   // watchdog
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      close_out();
   end

   // ====================================================================
   // tests
   initial begin
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      rdchk(FLG, 8'h00);
      rdchk(CTL, 8'h00);
      rdchk(ENA, 8'h00);
      wr(CTL, 8'hff);
      rdchk(CTL, 8'h3f);
      chk(pwm_mode, 1'b1);
      chk(duty, 2'b11);
      wr(LO, 8'ha5);
      wr(HI, 8'h5a);
      rdchk(LO, 8'ha5);
      rdchk(HI, 8'h5a);
      rdchk(8'h20, 8'h00);
      wr(CTL, 8'h00);
      // capture on rising edges, then a second capture over the value already read
      set_timer(16'h1234);
      wr(CTL, tcc_pkg::MODE_CAP_RISE);
      wr(FLG, 8'h00);
      rises(1);
      chk(irq_flag, 1'b1);
      rdchk(LO, 8'h34);
      rdchk(HI, 8'h12);
      set_timer(16'hbeef);
      rises(1);
      rdchk(LO, 8'hef);
      rdchk(HI, 8'hbe);
      rdchk(FLG, 8'h04);
      chk(irq_req, 1'b0);
      wr(ENA, 8'h04);
      chk(irq_req, 1'b1);
      wr(CTL, tcc_pkg::MODE_CAP_FALL);
      wr(FLG, 8'h00);
      set_timer(16'h0a0b);
      pin_to(1'b1);
      chk(irq_flag, 1'b0);
      pin_to(1'b0);
      chk(irq_flag, 1'b1);
      rdchk(LO, 8'h0b);
      // prescaled capture: 4th and 16th rising edge
      for (int m = 0; m < 2; m++) begin
         wr(CTL, 8'h00);
         wr(CTL, m ? tcc_pkg::MODE_CAP_RISE16 : tcc_pkg::MODE_CAP_RISE4);
         wr(FLG, 8'h00);
         rises(m ? 15 : 3);
         chk(irq_flag, 1'b0);
         rises(1);
         chk(irq_flag, 1'b1);
      end
      // turning the unit off must drop a half-counted prescale
      wr(FLG, 8'h00);
      rises(2);
      wr(CTL, 8'h00);
      wr(CTL, tcc_pkg::MODE_CAP_RISE4);
      rises(3);
      chk(irq_flag, 1'b0);
      // with ce low the fourth edge must not be seen at all
      ce <= 1'b0;
      rises(1);
      ce <= 1'b1;
      chk(irq_flag, 1'b0);
      // compare modes: pin action and flag on a match
      foreach (cmp_modes[i]) begin
         set_timer(16'h0100);
         wr(LO, 8'h03);
         wr(HI, 8'h01);
         wr(CTL, cmp_modes[i]);
         wr(FLG, 8'h00);
         run <= 1'b1;
         repeat (8) @(posedge clk);
         run <= 1'b0;
         @(posedge clk);
         chk(pin_out, cmp_pin[i]);
         chk(irq_flag, 1'b1);
      end
      // equality that persists flags only once
      set_timer(16'h0102);
      tick_once();
      repeat (3) @(posedge clk);
      wr(FLG, 8'h00);
      repeat (5) @(posedge clk);
      chk(irq_flag, 1'b0);
      wr(CTL, 8'h00);
      chk(pin_out, 1'b0);
      // special event trigger acts as the timer period
      set_timer(16'h0000);
      wr(LO, 8'h10);
      wr(HI, 8'h00);
      adc_enable <= 1'b1;
      wr(CTL, tcc_pkg::MODE_CMP_TRIGGER);
      run <= 1'b1;
      repeat (40) @(posedge clk);
      run <= 1'b0;
      @(posedge clk);
      chk(saw_trig, 1'b1);
      chk(saw_adc, 1'b1);
      chk(timer.count <= 16'h0010, 1'b1);
      // match withdrawn before the tick leaves the timer counting
      set_timer(16'h000f);
      tick_once();
      wr(LO, 8'h20);
      tick_once();
      chk(timer.count, 16'h0011);
      close_out();
   end
endmodule

/* File: verif/tcc_timer_model.sv */
// partner model: the 16-bit timer that feeds the unit and obeys its clear request
`timescale 1ns/1ps

module tcc_timer_model (
   input wire logic clk,
   input wire logic srst,
   input wire logic run,
   input wire logic load,
   input wire logic [15:0] load_value,
   input wire logic timer_clear,
   output tcc_pkg::tcc_timer_type timer
);
   logic [15:0] count_reg;

   // ====================================================================
   // timer counts the system clock, so capture and compare stay synchronous
   assign timer = {count_reg, run};

   // the clear request only acts on a tick; a request withdrawn before it is ignored
   always_ff @(posedge clk) begin
      if (srst) begin
         count_reg <= 16'h0000;
      end else if (load) begin
         count_reg <= load_value;
      end else if (run && timer_clear) begin
         count_reg <= 16'h0000;
      end else if (run) begin
         count_reg <= count_reg + 16'h0001;
      end
   end
endmodule
